// *** core/rmii_pkg.sv ***
// Shared constants and types for the RMII transceiver interface.
//
// Contract
// - All RMII signals timed from one 50MHz clock.
// - 25MHz mode: build 50MHz reference, drive it out.
// - 50MHz mode: take external reference, leave output undriven.
// - Capture TXD on every cycle with TXEN high; slow mode takes only one cycle in ten.
// - TXD idles 00; ignore TXD while TXEN low.
// - Raise CRS_DV when carrier is detected.
// - CRS_DV stays high until the last dibit is out.
// - Drop CRS_DV when carrier is lost.
// - RXD stays 00 until data is decoded.
// - RXD updates on reference clock, dibit per period.
// - RXD is 00 while CRS_DV is low.
// - Pulse RXER on a detected symbol error; an error that meets a low CRS_DV is dropped.
// - Power-up clock mode depends on device variant.
// - Mode swap control selects the opposite clock mode.
// - Both back-to-back controls plus 50MHz mode enable repeater.
// - Repeater: receive outputs feed peer transmit inputs; no such path here, repeater only forces one dibit per cycle.
// - Separate two-bit transmit and receive paths.
package rmii_pkg;

  typedef enum logic {
    CLOCK_MODE_25,
    CLOCK_MODE_50
  } clock_mode_type;

  localparam int CLK_MHZ          = 200;
  localparam int REF_CLK_MHZ      = 50;
  localparam int REF_HALF_CYCLES  = CLK_MHZ / (2 * REF_CLK_MHZ);
  localparam int DIV_WIDTH        = 4;

  localparam int          DIBIT_WIDTH     = 2;
  localparam int          BYTE_WIDTH      = 8;
  localparam int          DIBITS_PER_BYTE = BYTE_WIDTH / DIBIT_WIDTH;
  localparam logic [1:0]  IDLE_DIBIT      = 2'h0;
  localparam logic [3:0]  SLOW_REPEAT     = 4'ha;
  localparam logic [3:0]  REPEAT_ZERO     = 4'h0;
  localparam logic [2:0]  DIBIT_COUNT     = 3'h4;
  localparam logic [2:0]  COUNT_ZERO      = 3'h0;
  localparam logic [2:0]  COUNT_ONE       = 3'h1;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;

endpackage

// *** core/rmii_sync.sv ***
// Two-flop level synchronizer for a bundle of independent bits.
`timescale 1ns/1ps
module rmii_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock.
  input  wire logic             i_clk,
  // Asynchronous levels in, synchronized levels out.
  input  wire logic [WIDTH-1:0] i_level,
  output logic      [WIDTH-1:0] o_level
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type state_q;
  sync_state_type state_d;

  always_comb begin
    state_d.meta   = i_level;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge i_clk) begin
    state_q <= state_d;
  end

  assign o_level = state_q.stable;

endmodule

// *** core/rmii_clock_div.sv ***
// Divider that builds the reference clock from the core clock.
`timescale 1ns/1ps
module rmii_clock_div
  import rmii_pkg::*;
(
  // Core clock and reset.
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // Drive request.
  input  wire logic i_enable,
  // Reference clock pin.
  output logic      o_ref_clk,
  output logic      o_ref_clk_oe_n
);

  localparam logic [DIV_WIDTH-1:0] HALF_LAST =
    DIV_WIDTH'(REF_HALF_CYCLES - 1);

  typedef struct packed {
    logic [DIV_WIDTH-1:0] count;
    logic                 level;
    logic                 oe_n;
  } div_state_type;

  div_state_type state_q;
  div_state_type state_d;

  always_comb begin
    state_d      = state_q;
    state_d.oe_n = ~i_enable;
    if (!i_enable) begin
      state_d.count = '0;
      state_d.level = 1'b0;
    end else if (state_q.count == HALF_LAST) begin
      state_d.count = '0;
      state_d.level = ~state_q.level;
    end else begin
      state_d.count = state_q.count + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= '{count: '0, level: 1'b0, oe_n: 1'b1};
    end else begin
      state_q <= state_d;
    end
  end

  assign o_ref_clk      = state_q.level;
  assign o_ref_clk_oe_n = state_q.oe_n;

endmodule

// *** core/rmii_phy_interface.sv ***
// RMII transceiver interface: clock mode, transmit capture, receive drive.
`timescale 1ns/1ps
module rmii_phy_interface
  import rmii_pkg::*;
#(
  parameter clock_mode_type DEFAULT_MODE = CLOCK_MODE_25
) (
  // Core clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Configuration levels.
  input  wire logic       i_clock_mode_swap,
  input  wire logic       i_b2b_ctrl_a,
  input  wire logic       i_b2b_ctrl_b,
  input  wire logic       i_speed_100,
  // Reference clock at the link and its output pin.
  input  wire logic       i_ref_clk,
  output logic            o_ref_clk,
  output logic            o_ref_clk_oe_n,
  // Link transmit pins.
  input  wire logic       i_txen,
  input  wire logic [1:0] i_txd,
  // Link receive pins.
  output logic            o_crs_dv,
  output logic [1:0]      o_rxd,
  output logic            o_rxer,
  // Line side receive events.
  input  wire logic       i_carrier,
  input  wire logic       i_rx_decoded,
  input  wire logic [7:0] i_rx_byte,
  input  wire logic       i_rx_byte_valid,
  input  wire logic       i_rx_symbol_error,
  output logic            o_rx_ready,
  // Line side transmit data.
  output logic [7:0]      o_tx_byte,
  output logic            o_tx_byte_valid,
  output logic            o_tx_frame_end,
  output logic            o_tx_active,
  // Status.
  output logic            o_clock_mode_50,
  output logic            o_b2b_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers.

  // Shifts a new dibit in at the top of a transmit word.
  function automatic logic [7:0] put_dibit(input logic [7:0] word,
                                           input logic [1:0] dibit);
    put_dibit = {dibit, word[7:2]};
  endfunction

  // Shifts the oldest dibit out of a receive word.
  function automatic logic [7:0] drop_dibit(input logic [7:0] word);
    drop_dibit = {IDLE_DIBIT, word[7:2]};
  endfunction

  // Tells whether a toggle has moved since it was last seen.
  function automatic logic toggled(input logic now_level,
                                   input logic seen_level);
    toggled = (now_level != seen_level);
  endfunction

  // Tells whether the current dibit period ends on this edge.
  function automatic logic period_done(input logic       fast,
                                       input logic [3:0] rep);
    period_done = fast || (rep == SLOW_REPEAT - 1'b1);
  endfunction

  // Tells whether receive dibits remain to be sent.
  function automatic logic has_dibits(input logic [2:0] left);
    has_dibits = (left != COUNT_ZERO);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Crossing wires.

  logic [5:0] to_link;
  logic [5:0] at_link;
  logic [3:0] to_core;
  logic [3:0] at_core;

  logic link_reset_n;
  logic carrier_s;
  logic fast_s;
  logic decoded_s;
  logic rx_req_s;
  logic err_req_s;

  logic tx_tog_s;
  logic tx_end_s;
  logic txen_s;
  logic rx_ack_s;

  assign {link_reset_n, carrier_s, fast_s, decoded_s, rx_req_s, err_req_s}
    = at_link;
  assign {tx_tog_s, tx_end_s, txen_s, rx_ack_s} = at_core;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain state.

  typedef struct packed {
    clock_mode_type mode;
    logic           b2b;
    logic           fast;
    logic           tx_seen;
    logic           end_seen;
    logic [7:0]     tx_byte;
    logic           tx_valid;
    logic           tx_end;
    logic           tx_active;
    logic [7:0]     rx_hold;
    logic           rx_req;
    logic           rx_ready;
    logic           err_req;
  } core_state_type;

  core_state_type core_q;
  core_state_type core_d;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain state.

  typedef struct packed {
    logic       txen_prev;
    logic [3:0] tx_rep;
    logic [1:0] tx_cnt;
    logic [7:0] tx_shift;
    logic [7:0] tx_word;
    logic       tx_tog;
    logic       tx_end_tog;
    logic       rx_seen;
    logic       rx_ack;
    logic [7:0] rx_shift;
    logic [2:0] rx_left;
    logic [3:0] rx_rep;
    logic       err_seen;
    logic       crs_dv;
    logic [1:0] rxd;
    logic       rxer;
  } link_state_type;

  link_state_type link_q;
  link_state_type link_d;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain logic.

  rmii_sync #(.WIDTH(4)) u_sync_core (
    .i_clk   (i_clk),
    .i_level (to_core),
    .o_level (at_core)
  );

  rmii_clock_div u_clock_div (
    .i_clk          (i_clk),
    .i_reset_n      (i_reset_n),
    .i_enable       (core_q.mode == CLOCK_MODE_25),
    .o_ref_clk      (o_ref_clk),
    .o_ref_clk_oe_n (o_ref_clk_oe_n)
  );

  always_comb begin
    core_d          = core_q;
    core_d.mode     = clock_mode_type'(DEFAULT_MODE ^
                                       i_clock_mode_swap);
    core_d.b2b      = i_b2b_ctrl_a & i_b2b_ctrl_b &
                      (core_q.mode == CLOCK_MODE_50);
    core_d.fast     = i_speed_100 | core_q.b2b;
    core_d.tx_valid = 1'b0;
    core_d.tx_end   = 1'b0;
    core_d.tx_active = txen_s;
    core_d.tx_seen  = tx_tog_s;
    core_d.end_seen = tx_end_s;
    if (toggled(tx_tog_s, core_q.tx_seen)) begin
      core_d.tx_byte  = link_q.tx_word;
      core_d.tx_valid = 1'b1;
    end
    if (toggled(tx_end_s, core_q.end_seen)) begin
      core_d.tx_end = 1'b1;
    end
    if (i_rx_byte_valid && core_q.rx_ready) begin
      core_d.rx_hold  = i_rx_byte;
      core_d.rx_req   = ~core_q.rx_req;
      core_d.rx_ready = 1'b0;
    end else begin
      core_d.rx_ready = (core_q.rx_req == rx_ack_s);
    end
    if (i_rx_symbol_error) begin
      core_d.err_req = ~core_q.err_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      core_q <= '{mode: DEFAULT_MODE, default: '0};
    end else begin
      core_q <= core_d;
    end
  end

  // Words stay still until the toggle that announces them is seen.
  assign to_link = {i_reset_n, i_carrier, core_q.fast, i_rx_decoded,
                    core_q.rx_req, core_q.err_req};

  assign o_tx_byte       = core_q.tx_byte;
  assign o_tx_byte_valid = core_q.tx_valid;
  assign o_tx_frame_end  = core_q.tx_end;
  assign o_tx_active     = core_q.tx_active;
  assign o_rx_ready      = core_q.rx_ready;
  assign o_clock_mode_50 = (core_q.mode == CLOCK_MODE_50);
  assign o_b2b_active    = core_q.b2b;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain logic, clocked by the reference clock.

  // The link reset is the core reset after two reference clock flops.
  rmii_sync #(.WIDTH(6)) u_sync_link (
    .i_clk   (i_ref_clk),
    .i_level (to_link),
    .o_level (at_link)
  );

  logic tx_take;
  logic rx_step;
  logic rx_load;

  always_comb begin
    link_d           = link_q;
    link_d.txen_prev = i_txen;
    tx_take = 1'b0;
    if (i_txen) begin
      tx_take = fast_s || (link_q.tx_rep == REPEAT_ZERO);
      if (period_done(fast_s, link_q.tx_rep)) begin
        link_d.tx_rep = REPEAT_ZERO;
      end else begin
        link_d.tx_rep = link_q.tx_rep + 1'b1;
      end
    end else begin
      link_d.tx_rep = REPEAT_ZERO;
      link_d.tx_cnt = '0;
    end
    if (tx_take) begin
      link_d.tx_shift = put_dibit(link_q.tx_shift, i_txd);
      link_d.tx_cnt   = link_q.tx_cnt + 1'b1;
      if (link_q.tx_cnt == 2'(DIBITS_PER_BYTE - 1)) begin
        link_d.tx_word = put_dibit(link_q.tx_shift, i_txd);
        link_d.tx_tog  = ~link_q.tx_tog;
      end
    end
    if (link_q.txen_prev && !i_txen) begin
      link_d.tx_end_tog = ~link_q.tx_end_tog;
    end

    rx_step = has_dibits(link_q.rx_left) &&
              period_done(fast_s, link_q.rx_rep);
    rx_load = toggled(rx_req_s, link_q.rx_seen) &&
              (!has_dibits(link_q.rx_left) ||
               (rx_step && link_q.rx_left == COUNT_ONE));
    if (rx_load) begin
      link_d.rx_shift = core_q.rx_hold;
      link_d.rx_left  = DIBIT_COUNT;
      link_d.rx_rep   = REPEAT_ZERO;
      link_d.rx_seen  = rx_req_s;
      link_d.rx_ack   = rx_req_s;
    end else if (rx_step) begin
      link_d.rx_shift = drop_dibit(link_q.rx_shift);
      link_d.rx_left  = link_q.rx_left - 1'b1;
      link_d.rx_rep   = REPEAT_ZERO;
    end else if (has_dibits(link_q.rx_left)) begin
      link_d.rx_rep   = link_q.rx_rep + 1'b1;
    end

    link_d.crs_dv = carrier_s || has_dibits(link_d.rx_left);
    if (link_d.crs_dv && decoded_s && has_dibits(link_d.rx_left)) begin
      link_d.rxd = link_d.rx_shift[1:0];
    end else begin
      link_d.rxd = IDLE_DIBIT;
    end

    link_d.err_seen = err_req_s;
    // An error pulse that meets a low CRS_DV is dropped.
    link_d.rxer = toggled(err_req_s, link_q.err_seen) &&
                  link_d.crs_dv;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!link_reset_n) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  assign to_core = {link_q.tx_tog, link_q.tx_end_tog, link_q.txen_prev,
                    link_q.rx_ack};

  assign o_crs_dv = link_q.crs_dv;
  assign o_rxd    = link_q.rxd;
  assign o_rxer   = link_q.rxer;

endmodule

// *** verif/rmii_phy_interface_props.sv ***
// Assertions on the ports of the RMII transceiver interface.
`timescale 1ns/1ps
module rmii_phy_interface_props
  import rmii_pkg::*;
#(
  parameter clock_mode_type DEFAULT_MODE = CLOCK_MODE_25
) (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_clock_mode_swap,
  input wire logic       i_b2b_ctrl_a,
  input wire logic       i_b2b_ctrl_b,
  input wire logic       i_ref_clk,
  input wire logic       o_ref_clk,
  input wire logic       o_ref_clk_oe_n,
  input wire logic       o_crs_dv,
  input wire logic [1:0] o_rxd,
  input wire logic       o_rxer,
  input wire logic       i_rx_decoded,
  input wire logic       o_clock_mode_50,
  input wire logic       o_b2b_active
);
  logic b2b_want;
  assign b2b_want = i_b2b_ctrl_a & i_b2b_ctrl_b & o_clock_mode_50;
  sequence driving_s; !o_clock_mode_50 [*4]; endsequence
  sequence undecoded_s; !i_rx_decoded [*5]; endsequence
  mode_sel_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) $past(i_reset_n) && $stable(i_clock_mode_swap)
    |-> o_clock_mode_50 == (DEFAULT_MODE ^ i_clock_mode_swap))
    else $error("clock mode wrong");
  b2b_enable_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) $past(i_reset_n, 3) && $past(b2b_want) ==
    b2b_want && $past(b2b_want, 2) == b2b_want |-> o_b2b_active == b2b_want)
    else $error("back to back state wrong");
  ext_ref_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) o_clock_mode_50 && $past(o_clock_mode_50, 2)
    |-> o_ref_clk_oe_n) else $error("reference driven in 50MHz mode");
  own_ref_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) driving_s |-> !o_ref_clk_oe_n)
    else $error("reference not driven");
  ref_toggle_a: assert property (@(posedge i_clk)
    disable iff (!i_reset_n) !o_ref_clk_oe_n && $past(!o_ref_clk_oe_n, 4)
    |-> o_ref_clk != $past(o_ref_clk, 2)) else $error("reference rate wrong");
  rxd_idle_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n) !o_crs_dv |-> o_rxd == IDLE_DIBIT)
    else $error("receive data not idle");
  rxer_frame_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n) o_rxer |-> o_crs_dv)
    else $error("receive error outside frame");
  rxd_undecoded_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_reset_n) undecoded_s |-> o_rxd == IDLE_DIBIT)
    else $error("data before decode");
endmodule
bind rmii_phy_interface rmii_phy_interface_props #(
  .DEFAULT_MODE(DEFAULT_MODE)
) u_props (.i_clk, .i_reset_n, .i_clock_mode_swap, .i_b2b_ctrl_a,
  .i_b2b_ctrl_b, .i_ref_clk, .o_ref_clk, .o_ref_clk_oe_n, .o_crs_dv, .o_rxd,
  .o_rxer, .i_rx_decoded, .o_clock_mode_50, .o_b2b_active);

// *** verif/rmii_mac_model.sv ***
// Behavioural MAC at the far side of the RMII link.
`timescale 1ns/1ps
module rmii_mac_model
  import rmii_pkg::*;
(
  // Link clock, speed and idle pattern request.
  input  wire logic       i_ref_clk,
  input  wire logic       i_slow,
  input  wire logic       i_junk,
  // Transmit pins.
  output logic            o_txen,
  output logic [1:0]      o_txd,
  // Receive pins.
  input  wire logic       i_crs_dv,
  input  wire logic [1:0] i_rxd,
  input  wire logic       i_rxer
);
  logic [7:0] rx_q[$];
  logic [7:0] sh = 8'h00;
  int         n_dib = 0;
  int         ph = 0;
  int         n_err = 0;
  int         n_col = 0;
  initial o_txen = 1'b0;
  initial o_txd = IDLE_DIBIT;
  task automatic send(input logic [7:0] b, input logic last);
    for (int i = 0; i < DIBITS_PER_BYTE; i++) begin
      repeat (i_slow ? 10 : 1) begin
        @(posedge i_ref_clk);
        o_txen <= 1'b1;
        o_txd <= b[2*i +: 2];
      end
    end
    if (last) begin
      @(posedge i_ref_clk);
      o_txen <= 1'b0;
      o_txd <= i_junk ? 2'h3 : IDLE_DIBIT;
    end
  endtask
  always @(negedge i_ref_clk) begin
    if (o_txen === 1'b1 && i_crs_dv === 1'b1) n_col++;
    if (i_crs_dv !== 1'b1) begin
      ph = 0;
      n_dib = 0;
    end else begin
      if (i_rxer === 1'b1) n_err++;
      if (ph == 0) begin
        sh = {i_rxd, sh[7:2]};
        n_dib++;
      end
      if (n_dib == DIBITS_PER_BYTE) begin
        rx_q.push_back(sh);
        n_dib = 0;
      end
      ph = (i_slow && ph < 9) ? ph + 1 : 0;
    end
  end
endmodule

// *** verif/rmii_phy_interface_tb_top.sv ***
// Self-checking bench for the RMII transceiver interface.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module rmii_phy_interface_tb_top import rmii_pkg::*;;
  logic i_clk = 0, i_ref_clk = 0, i_reset_n = 0, i_clock_mode_swap = 0;
  logic i_b2b_ctrl_a = 0, i_b2b_ctrl_b = 0, i_speed_100 = 1, i_carrier = 0;
  logic i_rx_decoded = 0, i_rx_byte_valid = 0, i_rx_symbol_error = 0;
  logic [7:0] i_rx_byte = 8'h00, o_tx_byte;
  logic [1:0] i_txd, o_rxd;
  logic i_txen, o_ref_clk, o_ref_clk_oe_n, o_crs_dv, o_rxer, o_rx_ready;
  logic o_tx_byte_valid, o_tx_frame_end, o_tx_active, o_clock_mode_50;
  logic o_b2b_active, junk = 0;
  logic [7:0] tx_q[$];
  int n_fail = 0, cmp_count = 0, n_end = 0, n_act = 0;
  always #2.5 i_clk = ~i_clk;
  always #6 i_ref_clk = ~i_ref_clk;
  rmii_phy_interface #(.DEFAULT_MODE(CLOCK_MODE_25)) u_dut (
    .i_clk, .i_reset_n, .i_clock_mode_swap, .i_b2b_ctrl_a, .i_b2b_ctrl_b,
    .i_speed_100, .i_ref_clk, .o_ref_clk, .o_ref_clk_oe_n, .i_txen, .i_txd,
    .o_crs_dv, .o_rxd, .o_rxer, .i_carrier, .i_rx_decoded, .i_rx_byte,
    .i_rx_byte_valid, .i_rx_symbol_error, .o_rx_ready, .o_tx_byte,
    .o_tx_byte_valid, .o_tx_frame_end, .o_tx_active, .o_clock_mode_50,
    .o_b2b_active);
  rmii_mac_model u_mac (.i_ref_clk, .i_slow(!i_speed_100), .i_junk(junk),
    .o_txen(i_txen), .o_txd(i_txd), .i_crs_dv(o_crs_dv), .i_rxd(o_rxd),
    .i_rxer(o_rxer));
  always @(negedge i_clk) begin
    if (o_tx_byte_valid === 1'b1) tx_q.push_back(o_tx_byte);
    if (o_tx_active === 1'b1) n_act++;
    if (o_tx_frame_end === 1'b1) n_end++;
  end
  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cfg(input logic s, input logic a, input logic b);
    @(negedge i_clk);
    i_clock_mode_swap = s;
    i_b2b_ctrl_a = a;
    i_b2b_ctrl_b = b;
    repeat (6) @(negedge i_clk);
  endtask
  task automatic t_mode();
    int n;
    logic p;
    n = 0;
    p = o_ref_clk;
    `CHK(o_clock_mode_50, 1'b0)
    `CHK(o_ref_clk_oe_n, 1'b0)
    repeat (8) begin
      @(negedge i_clk);
      if (o_ref_clk !== p) n++;
      p = o_ref_clk;
    end
    `CHK(n, 4)
    cfg(1, 0, 1);
    `CHK(o_clock_mode_50, 1'b1)
    `CHK(o_ref_clk_oe_n, 1'b1)
    `CHK(o_b2b_active, 1'b0)
    cfg(1, 1, 1);
    `CHK(o_b2b_active, 1'b1)
    cfg(0, 1, 1);
    `CHK(o_b2b_active, 1'b0)
    cfg(0, 0, 0);
    $display("mode test done");
  endtask
  task automatic t_tx();
    junk = 0;
    u_mac.send(8'h1b, 0);
    junk = 1;
    u_mac.send(8'he4, 1);
    repeat (100) @(negedge i_clk);
    i_speed_100 = 0;
    repeat (10) @(negedge i_clk);
    u_mac.send(8'h93, 1);
    repeat (200) @(negedge i_clk);
    `CHK(tx_q.size(), 3)
    `CHK(tx_q[0], 8'h1b)
    `CHK(tx_q[1], 8'he4)
    `CHK(tx_q[2], 8'h93)
    `CHK(n_end, 2)
    `CHK(n_act > 0, 1'b1)
    `CHK(o_tx_active, 1'b0)
    $display("transmit test done");
  endtask
  task automatic t_crs();
    @(negedge i_clk);
    i_speed_100 = 1;
    i_carrier = 1;
    repeat (20) @(negedge i_clk);
    `CHK(o_crs_dv, 1'b1)
    u_mac.send(8'h5a, 1);
    `CHK(u_mac.n_col > 0, 1'b1)
    @(negedge i_clk);
    i_carrier = 0;
    repeat (20) @(negedge i_clk);
    `CHK(o_crs_dv, 1'b0)
    u_mac.rx_q = {};
    offer(8'hff);
    repeat (40) @(negedge i_clk);
    `CHK(u_mac.rx_q.size(), 1)
    `CHK(u_mac.rx_q[0], 8'h00)
    $display("carrier test done");
  endtask
  task automatic offer(input logic [7:0] b);
    int k;
    k = 0;
    @(negedge i_clk);
    i_rx_byte = b;
    i_rx_byte_valid = 1;
    while (o_rx_ready !== 1'b1 && k < 400) begin
      @(negedge i_clk);
      k++;
    end
    `CHK(k < 400, 1'b1)
    @(negedge i_clk);
    i_rx_byte_valid = 0;
  endtask
  task automatic t_rx(input logic fast);
    int k;
    k = 0;
    @(negedge i_clk);
    i_speed_100 = fast;
    i_rx_decoded = 1;
    repeat (10) @(negedge i_clk);
    u_mac.rx_q = {};
    u_mac.n_err = 0;
    offer(8'h2d);
    while (o_crs_dv !== 1'b1 && k < 100) begin
      @(negedge i_clk);
      k++;
    end
    `CHK(o_crs_dv, 1'b1)
    i_rx_symbol_error = 1;
    @(negedge i_clk);
    i_rx_symbol_error = 0;
    offer(8'hc6);
    repeat (fast ? 100 : 400) @(negedge i_clk);
    `CHK(o_crs_dv, 1'b0)
    `CHK(o_rxd, IDLE_DIBIT)
    `CHK(u_mac.rx_q.size(), 2)
    `CHK(u_mac.rx_q[0], 8'h2d)
    `CHK(u_mac.rx_q[1], 8'hc6)
    `CHK(u_mac.n_err > 0, 1'b1)
    $display("receive test done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (12) @(negedge i_clk);
    i_reset_n = 1;
    repeat (12) @(negedge i_clk);
    t_mode();
    t_tx();
    t_crs();
    t_rx(1);
    t_rx(0);
    end_sim();
  end
endmodule
